//--- rtl/iqd_pkg.sv
// Shared types and constants of the instruction queue and decode block
// Functional notes
// - Instruction queue holds at most 18 predecoded instructions.
// - At most five queue entries go toward the decoders per cycle.
// - At most one macro-fusion per cycle.
// - Macro-fusion only outside 64-bit mode.
// - Loop cache only for loop bodies shorter than 18 instructions.
// - Detected loop is locked and replayed until a misprediction ends it.
// - During playback fetch, branch predictor and predecode may idle.
// - Playback has no taken-branch, misalignment or prefix-length bubbles.
// - Four decoders; the first, complex one takes flows up to 4 micro-ops.
// - Other three decoders each take single micro-op flows.
// - Microsequencer supplies flows over four micro-ops, 3 per cycle at most.
// - All decoders take flows made single by micro-fusion, stack tracking, macro-fusion.
// - Macro-fusion turns two adjacent instructions into one micro-op.
// - Implicit stack pointer updates come from decoder logic, not micro-ops.
// - Push, pop and return each decode to exactly one micro-op.
// - Micro-fusion folds two micro-ops of a memory-operand flow into one complex micro-op.
package iqd_pkg;
    localparam int QUEUE_DEPTH = 18;
    localparam int IN_LANES = 6;
    localparam int DECODERS = 4;
    localparam int PAYLOAD_W = 32;
    localparam int UOP_W = 4;
    localparam int LEN_W = 5;
    localparam int PTR_W = 5;
    localparam int SP_W = 8;
    localparam logic [PTR_W-1:0] DELIVER_MAX = 5'h05;
    localparam logic [UOP_W-1:0] UOP_ONE = 4'h1;
    localparam logic [UOP_W-1:0] COMPLEX_MAX_UOPS = 4'h4;
    localparam logic [UOP_W-1:0] USEQ_UOPS_PER_CYCLE = 4'h3;
    localparam logic [SP_W-1:0] SP_STEP_32 = 8'h04;
    localparam logic [SP_W-1:0] SP_STEP_64 = 8'h08;
    localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;

    typedef enum logic [2:0] {
        STK_NONE,
        STK_PUSH,
        STK_POP,
        STK_CALL,
        STK_LEAVE,
        STK_RET
    } iqd_stack_t;

    // One predecoded instruction as written by the predecoder
    typedef struct packed {
        logic [PAYLOAD_W-1:0] payload;
        logic [UOP_W-1:0] uop_len;
        logic mem_form;
        iqd_stack_t stk_kind;
        logic fuse_head;
        logic fuse_tail;
        logic br_back;
        logic [LEN_W-1:0] loop_len;
    } iqd_entry_t;
endpackage

//--- rtl/iqd_decode_front.sv
// Instruction queue with loop playback and four-wide decode
`timescale 1ns/10ps
`default_nettype none
module iqd_decode_front #(
    parameter int DEPTH = iqd_pkg::QUEUE_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Core mode and redirect
    input wire logic mode_64,
    input wire logic mispredict,
    // Predecoder side
    input wire logic [iqd_pkg::IN_LANES-1:0] in_valid,
    input wire iqd_pkg::iqd_entry_t [iqd_pkg::IN_LANES-1:0] in_entry,
    output logic in_ready,
    output logic fe_idle,
    // Renamer side
    output logic out_valid,
    input wire logic out_ready,
    output logic [iqd_pkg::DECODERS-1:0] lane_valid,
    output logic [iqd_pkg::DECODERS-1:0][iqd_pkg::PAYLOAD_W-1:0] lane_payload,
    output logic [iqd_pkg::DECODERS-1:0][iqd_pkg::UOP_W-1:0] lane_uops,
    output logic [iqd_pkg::DECODERS-1:0] lane_macro_fused,
    output logic [iqd_pkg::DECODERS-1:0] lane_micro_fused,
    output logic [iqd_pkg::DECODERS-1:0] lane_from_useq,
    output logic [iqd_pkg::DECODERS-1:0][iqd_pkg::SP_W-1:0] lane_sp_delta
);
    import iqd_pkg::*;

    localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0] LANES_P = PTR_W'(IN_LANES);

    typedef struct packed {
        iqd_entry_t [DEPTH-1:0] mem;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] count;
        logic [PTR_W-1:0] hist;
        logic loop_lock;
        logic [PTR_W-1:0] loop_start;
        logic [PTR_W-1:0] loop_end;
        logic cand_valid;
        logic [LEN_W-1:0] cand_len;
        logic useq_busy;
        logic [UOP_W-1:0] useq_left;
        iqd_entry_t useq_entry;
        logic in_ready;
        logic out_valid;
        logic [DECODERS-1:0] lane_valid;
        logic [DECODERS-1:0][PAYLOAD_W-1:0] lane_payload;
        logic [DECODERS-1:0][UOP_W-1:0] lane_uops;
        logic [DECODERS-1:0] lane_macro_fused;
        logic [DECODERS-1:0] lane_micro_fused;
        logic [DECODERS-1:0] lane_from_useq;
        logic [DECODERS-1:0][SP_W-1:0] lane_sp_delta;
    } iqd_state_t;

    iqd_state_t st;
    iqd_state_t next_st;

    // Next queue slot; in playback the loop end wraps to its start
    function automatic logic [PTR_W-1:0] step_idx(input logic [PTR_W-1:0] idx,
                                                   input logic lock,
                                                   input logic [PTR_W-1:0] ls,
                                                   input logic [PTR_W-1:0] le);
        logic [PTR_W-1:0] r;
        r = (idx == DEPTH_P - 5'h01) ? PTR_RESET : idx + 5'h01;
        if (lock && idx == le) begin
            r = ls;
        end
        return r;
    endfunction

    // Micro-ops left after stack tracking and micro-fusion
    function automatic logic [UOP_W-1:0] eff_uops(input iqd_entry_t e);
        logic [UOP_W-1:0] n;
        n = (e.uop_len == 4'h0) ? UOP_ONE : e.uop_len;
        if (e.stk_kind == STK_PUSH || e.stk_kind == STK_POP || e.stk_kind == STK_RET) begin
            n = UOP_ONE;
        end else begin
            if (e.stk_kind != STK_NONE && n > UOP_ONE) begin
                n = n - UOP_ONE;
            end
            if (e.mem_form && n > UOP_ONE) begin
                n = n - UOP_ONE;
            end
        end
        return n;
    endfunction

    // Implicit stack pointer change worked out beside the decoder
    function automatic logic [SP_W-1:0] sp_delta(input iqd_entry_t e, input logic m64);
        logic [SP_W-1:0] s;
        logic [SP_W-1:0] d;
        s = m64 ? SP_STEP_64 : SP_STEP_32;
        d = 8'h00;
        case (e.stk_kind)
            STK_PUSH, STK_CALL: d = 8'h00 - s;
            STK_POP, STK_RET, STK_LEAVE: d = s;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    always_comb begin
        logic [PTR_W-1:0] idx;
        logic [PTR_W-1:0] taken;
        logic [PTR_W-1:0] avail;
        logic [PTR_W-1:0] accepted;
        logic [PTR_W-1:0] widx;
        logic [PTR_W-1:0] bidx;
        logic [PTR_W-1:0] hist_sum;
        logic [PTR_W-1:0] free_room;
        logic stop;
        logic fused;
        logic lock_now;
        logic fire;
        logic [UOP_W-1:0] eff;
        iqd_entry_t e;
        iqd_entry_t last;
        int start_i;
        idx = st.rd_ptr;
        taken = PTR_RESET;
        accepted = PTR_RESET;
        widx = st.wr_ptr;
        bidx = PTR_RESET;
        hist_sum = PTR_RESET;
        free_room = PTR_RESET;
        stop = 1'b0;
        fused = 1'b0;
        lock_now = 1'b0;
        eff = 4'h0;
        e = '0;
        last = '0;
        start_i = 0;
        next_st = st;
        // Bundle holds until the renamer takes it
        fire = !st.out_valid || out_ready;
        avail = st.loop_lock ? DELIVER_MAX : st.count;
        if (fire) begin
            next_st.out_valid = 1'b0;
            next_st.lane_valid = '0;
            next_st.lane_payload = '0;
            next_st.lane_uops = '0;
            next_st.lane_macro_fused = '0;
            next_st.lane_micro_fused = '0;
            next_st.lane_from_useq = '0;
            next_st.lane_sp_delta = '0;
            if (st.useq_busy) begin
                // Long flow owns the complex slot until finished
                next_st.lane_valid[0] = 1'b1;
                next_st.lane_payload[0] = st.useq_entry.payload;
                next_st.lane_from_useq[0] = 1'b1;
                if (st.useq_left > USEQ_UOPS_PER_CYCLE) begin
                    next_st.lane_uops[0] = USEQ_UOPS_PER_CYCLE;
                    next_st.useq_left = st.useq_left - USEQ_UOPS_PER_CYCLE;
                end else begin
                    next_st.lane_uops[0] = st.useq_left;
                    next_st.useq_left = 4'h0;
                    next_st.useq_busy = 1'b0;
                end
                next_st.out_valid = 1'b1;
                stop = 1'b1;
            end
            for (int d = 0; d < DECODERS; d++) begin
                if (!stop && taken < avail) begin
                    e = st.mem[idx];
                    eff = eff_uops(e);
                    if (d == 0 && eff > COMPLEX_MAX_UOPS) begin
                        // Hand the flow to the microsequencer
                        next_st.useq_busy = 1'b1;
                        next_st.useq_entry = e;
                        next_st.useq_left = eff - USEQ_UOPS_PER_CYCLE;
                        next_st.lane_valid[0] = 1'b1;
                        next_st.lane_payload[0] = e.payload;
                        next_st.lane_uops[0] = USEQ_UOPS_PER_CYCLE;
                        next_st.lane_from_useq[0] = 1'b1;
                        next_st.out_valid = 1'b1;
                        idx = step_idx(idx, st.loop_lock, st.loop_start, st.loop_end);
                        taken = taken + 5'h01;
                        stop = 1'b1;
                    end else if (d != 0 && eff != UOP_ONE) begin
                        stop = 1'b1;
                    end else begin
                        next_st.lane_valid[d] = 1'b1;
                        next_st.lane_payload[d] = e.payload;
                        next_st.lane_uops[d] = eff;
                        next_st.lane_micro_fused[d] = e.mem_form && e.uop_len > UOP_ONE;
                        next_st.lane_sp_delta[d] = sp_delta(e, mode_64);
                        next_st.out_valid = 1'b1;
                        last = e;
                        bidx = idx;
                        hist_sum = st.hist + taken;
                        // Playback wraps at the loop end in the same cycle
                        idx = step_idx(idx, st.loop_lock, st.loop_start, st.loop_end);
                        taken = taken + 5'h01;
                        if (!fused && !mode_64 && e.fuse_head && eff == UOP_ONE
                            && taken < avail && st.mem[idx].fuse_tail) begin
                            fused = 1'b1;
                            next_st.lane_macro_fused[d] = 1'b1;
                            last = st.mem[idx];
                            bidx = idx;
                            hist_sum = st.hist + taken;
                            idx = step_idx(idx, st.loop_lock, st.loop_start, st.loop_end);
                            taken = taken + 5'h01;
                        end
                        if (!st.loop_lock && last.br_back) begin
                            stop = 1'b1;
                            // Lock only a repeated, still intact short body
                            if (last.loop_len != 5'h00 && PTR_W'(last.loop_len) < DEPTH_P
                                && PTR_W'(last.loop_len) <= hist_sum + 5'h01) begin
                                if (st.cand_valid && st.cand_len == last.loop_len) begin
                                    lock_now = 1'b1;
                                    start_i = int'(bidx) + DEPTH - int'(last.loop_len) + 1;
                                    if (start_i >= DEPTH) begin
                                        start_i = start_i - DEPTH;
                                    end
                                    next_st.loop_start = PTR_W'(start_i);
                                    next_st.loop_end = bidx;
                                end else begin
                                    next_st.cand_valid = 1'b1;
                                    next_st.cand_len = last.loop_len;
                                end
                            end
                        end
                    end
                end
            end
        end
        next_st.rd_ptr = idx;
        // Writes arriving in the lock cycle are fall-through and are dropped
        if (st.in_ready && !st.loop_lock && !lock_now) begin
            for (int k = 0; k < IN_LANES; k++) begin
                if (in_valid[k]) begin
                    next_st.mem[widx] = in_entry[k];
                    widx = step_idx(widx, 1'b0, PTR_RESET, PTR_RESET);
                    accepted = accepted + 5'h01;
                end
            end
        end
        next_st.wr_ptr = widx;
        if (st.loop_lock || lock_now) begin
            next_st.count = PTR_RESET;
            next_st.hist = PTR_RESET;
        end else begin
            next_st.count = st.count - taken + accepted;
            free_room = DEPTH_P - next_st.count;
            hist_sum = st.hist + taken;
            next_st.hist = (hist_sum > free_room) ? free_room : hist_sum;
        end
        if (lock_now) begin
            next_st.loop_lock = 1'b1;
            next_st.rd_ptr = next_st.loop_start;
            next_st.cand_valid = 1'b0;
        end
        // Ready is registered, so it asks for a full group of free slots
        next_st.in_ready = !next_st.loop_lock
            && (DEPTH_P - next_st.count >= LANES_P);
        if (mispredict) begin
            // Misprediction ends playback and flushes everything queued
            next_st.loop_lock = 1'b0;
            next_st.rd_ptr = PTR_RESET;
            next_st.wr_ptr = PTR_RESET;
            next_st.count = PTR_RESET;
            next_st.hist = PTR_RESET;
            next_st.cand_valid = 1'b0;
            next_st.useq_busy = 1'b0;
            next_st.useq_left = 4'h0;
            next_st.out_valid = 1'b0;
            next_st.lane_valid = '0;
            next_st.in_ready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready = st.in_ready;
    assign fe_idle = st.loop_lock;
    assign out_valid = st.out_valid;
    assign lane_valid = st.lane_valid;
    assign lane_payload = st.lane_payload;
    assign lane_uops = st.lane_uops;
    assign lane_macro_fused = st.lane_macro_fused;
    assign lane_micro_fused = st.lane_micro_fused;
    assign lane_from_useq = st.lane_from_useq;
    assign lane_sp_delta = st.lane_sp_delta;
endmodule // iqd_decode_front
`default_nettype wire

//--- tb/iqd_front_asserts.sv
// Port checker of the instruction queue and decode block
`timescale 1ns/10ps
`default_nettype none
module iqd_front_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Core side
    input wire logic mode_64,
    input wire logic mispredict,
    input wire logic in_ready,
    input wire logic fe_idle,
    // Renamer side
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [iqd_pkg::DECODERS-1:0] lane_valid,
    input wire logic [iqd_pkg::DECODERS-1:0][iqd_pkg::PAYLOAD_W-1:0] lane_payload,
    input wire logic [iqd_pkg::DECODERS-1:0][iqd_pkg::UOP_W-1:0] lane_uops,
    input wire logic [iqd_pkg::DECODERS-1:0] lane_macro_fused,
    input wire logic [iqd_pkg::DECODERS-1:0] lane_from_useq
);
    import iqd_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_hold_stall: assert property (out_valid && !out_ready && !mispredict |=> out_valid && $stable(lane_valid) && $stable(lane_payload) && $stable(lane_uops))
        else $error("bundle moved while stalled");
    chk_simple_lanes: assert property (out_valid |-> (lane_valid[3:1] & {lane_uops[3] != UOP_ONE, lane_uops[2] != UOP_ONE, lane_uops[1] != UOP_ONE}) == 3'h0)
        else $error("simple lane over one uop");
    chk_complex_max: assert property (out_valid && lane_valid[0] |-> lane_uops[0] != 4'h0 && lane_uops[0] <= COMPLEX_MAX_UOPS)
        else $error("lane 0 uop count out of range");
    chk_useq_rate: assert property (out_valid && lane_from_useq[0] |-> lane_uops[0] <= USEQ_UOPS_PER_CYCLE && lane_valid[3:1] == 3'h0)
        else $error("microsequencer chunk too large");
    chk_one_fusion: assert property (out_valid |-> $onehot0(lane_macro_fused))
        else $error("two fused lanes");
    chk_no_fuse64: assert property (out_valid && $past(mode_64) |-> lane_macro_fused == 4'h0)
        else $error("fusion in 64-bit mode");
    chk_playback_stall: assert property (fe_idle |-> !in_ready)
        else $error("queue open during playback");
    chk_mispredict_ends: assert property (mispredict |=> !out_valid && !fe_idle)
        else $error("playback survived redirect");
    cov_playback: cover property ($rose(fe_idle));
    cov_fusion: cover property (out_valid && lane_macro_fused != 4'h0);
    cov_useq: cover property (out_valid && lane_from_useq[0]);
endmodule // iqd_front_asserts
bind iqd_decode_front iqd_front_asserts u_chk (.clk(clk), .reset_n(reset_n),
    .mode_64(mode_64), .mispredict(mispredict), .in_ready(in_ready), .fe_idle(fe_idle),
    .out_valid(out_valid), .out_ready(out_ready), .lane_valid(lane_valid),
    .lane_payload(lane_payload), .lane_uops(lane_uops),
    .lane_macro_fused(lane_macro_fused), .lane_from_useq(lane_from_useq));
`default_nettype wire

//--- tb/iqd_renamer.sv
// Renamer model draining decoded bundles
`timescale 1ns/10ps
`default_nettype none
module iqd_renamer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Behaviour select
    input wire logic hold,
    input wire logic slow,
    // Handshake
    output logic out_ready
);
    // Moves only after an edge, so a bundle is taken where it is sampled
    always @(posedge clk) begin
        if (!reset_n || hold)
            out_ready <= 1'b0;
        else
            out_ready <= slow ? 1'($urandom % 2) : 1'b1;
    end
endmodule // iqd_renamer
`default_nettype wire

//--- tb/tb_instruction_queue_and_decode.sv
// Self-checking bench of the instruction queue and decode block
`timescale 1ns/10ps
`default_nettype none
module tb_instruction_queue_and_decode;
    import iqd_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic mode_64 = 1'b0;
    logic mispredict = 1'b0;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic loop_on = 1'b0;
    logic [IN_LANES-1:0] in_valid = '0;
    iqd_entry_t [IN_LANES-1:0] in_entry = '0;
    logic in_ready, fe_idle, out_valid, out_ready;
    logic [DECODERS-1:0] lane_valid, lane_macro_fused, lane_micro_fused, lane_from_useq;
    logic [DECODERS-1:0][PAYLOAD_W-1:0] lane_payload;
    logic [DECODERS-1:0][UOP_W-1:0] lane_uops;
    logic [DECODERS-1:0][SP_W-1:0] lane_sp_delta;
    logic [47:0] exp_q[$];
    int n_fail = 0;
    int checks_done = 0;
    int serial = 0;
    int got = 0;
    int n = 0;
    always #5 clk = ~clk;
    iqd_decode_front DUT (.clk(clk), .reset_n(reset_n), .mode_64(mode_64),
        .mispredict(mispredict), .in_valid(in_valid), .in_entry(in_entry), .in_ready(in_ready),
        .fe_idle(fe_idle), .out_valid(out_valid), .out_ready(out_ready),
        .lane_valid(lane_valid), .lane_payload(lane_payload), .lane_uops(lane_uops),
        .lane_macro_fused(lane_macro_fused), .lane_micro_fused(lane_micro_fused),
        .lane_from_useq(lane_from_useq), .lane_sp_delta(lane_sp_delta));
    iqd_renamer u_ren (.clk(clk), .reset_n(reset_n), .hold(hold), .slow(slow),
        .out_ready(out_ready));
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic die(input string m);
        n_fail++;
        $display("BAD %0t %s", $time, m);
        stop_test;
    endtask
    function automatic iqd_entry_t ent(input int p, input int raw, input int stk, input bit mem);
        iqd_entry_t e;
        e = '0;
        e.payload = 32'(p);
        e.uop_len = 4'(raw);
        e.stk_kind = iqd_stack_t'(stk);
        e.mem_form = mem;
        return e;
    endfunction
    // Long flows kept free of stack and memory forms, where chunking is not pinned down
    // Fused heads only in 5- and 6-wide groups, so no bundle meets two heads
    function automatic iqd_entry_t rnd(input int b, input int i);
        int k;
        int r;
        serial++;
        k = $urandom % 6;
        r = 1 + $urandom % 7;
        if (b % 6 >= 4 && (i == 2 || i == 3))
            return ent(serial, 1, 0, 1'b0) | {i == 2, i == 3, 6'h00};
        if (k != 0)
            r = 1 + r % 4;
        return ent(serial, r, k, k == 0 && r <= 5 && $urandom % 2 == 1);
    endfunction
    task automatic model(input int cnt);
        iqd_entry_t e;
        int eff;
        int c;
        logic uf, sq;
        logic [7:0] sp, st;
        st = mode_64 ? SP_STEP_64 : SP_STEP_32;
        for (int i = 0; i < cnt; i++) begin
            e = in_entry[i];
            if (e.fuse_head && !mode_64) begin
                exp_q.push_back({e.payload, UOP_ONE, 4'h8, 8'h00});
                i++;
                continue;
            end
            eff = e.uop_len;
            if (e.stk_kind inside {STK_PUSH, STK_POP, STK_RET})
                eff = 1;
            if (e.stk_kind inside {STK_CALL, STK_LEAVE} || e.mem_form)
                eff = eff > 1 ? eff - 1 : 1;
            sp = e.stk_kind inside {STK_PUSH, STK_CALL} ? 8'(-st) : 8'h00;
            sp = e.stk_kind inside {STK_POP, STK_RET, STK_LEAVE} ? st : sp;
            uf = e.mem_form && e.uop_len > 1;
            sq = eff > 4;
            do begin
                c = sq && eff > 3 ? 3 : eff;
                exp_q.push_back({e.payload, 4'(c), 1'b0, uf, sq, 1'b0, sp});
                eff -= c;
            end while (eff > 0);
        end
    endtask
    // Called in the time step of a rising edge
    task automatic wr(input int cnt, input bit must);
        in_valid <= IN_LANES'((1 << cnt) - 1);
        got = 0;
        for (int k = 0; k < 60 && got == 0; k++) begin
            #1;
            got = in_ready;
            @(posedge clk);
        end
        in_valid <= '0;
        if (got == 1)
            model(cnt);
        else if (must)
            die("write never taken");
    endtask
    task automatic drain;
        for (int k = 0; k < 500 && exp_q.size() > 0; k++)
            @(posedge clk);
        if (exp_q.size() > 0)
            die("output never drained");
        repeat (4) @(posedge clk);
    endtask
    task automatic loop_try(input int len, input bit lock);
        loop_on = lock;
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            for (int i = 0; i < IN_LANES; i++)
                in_entry[i] <= ent(256 + i, 1, 0, 1'b0) | ((i == 3) ? {6'h01, 5'(len)} : 11'h0);
            wr(4, 1);
        end
        got = 0;
        for (int k = 0; k < 40 && got == 0; k++) begin
            @(posedge clk);
            #1;
            got = fe_idle;
        end
        chk(48'(got), 48'(lock));
        if (lock) begin
            repeat (12) begin
                @(posedge clk);
                #1;
                chk({out_valid, in_ready, fe_idle}, 48'h5);
            end
            @(posedge clk);
            mispredict <= 1'b1;
            @(posedge clk);
            mispredict <= 1'b0;
            #1;
            chk({out_valid, fe_idle}, 48'h0);
            exp_q.delete();
        end
        drain;
        loop_on = 1'b0;
        $display("loop test len %0d done", len);
    endtask
    always @(negedge clk) begin
        if (reset_n && out_valid === 1'b1 && out_ready === 1'b1) begin
            for (int i = 0; i < DECODERS; i++) begin
                if (lane_valid[i] === 1'b1 && exp_q.size() > 0)
                    chk({lane_payload[i], lane_uops[i], lane_macro_fused[i], lane_micro_fused[i],
                        lane_from_useq[i], 1'b0, lane_sp_delta[i]}, exp_q.pop_front());
                else if (lane_valid[i] === 1'b1)
                    chk({loop_on, lane_payload[i][31:4]}, 48'h10000010);
            end
        end
    end
    initial begin
        #900000;
        die("run limit");
    end
    initial begin
        void'($urandom(32'h607fd421));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({in_ready, out_valid, fe_idle, lane_valid}, 48'h40);
        $display("reset test done");
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            mode_64 <= (m == 1);
            slow <= 1'b1;
            for (int b = 0; b < 12; b++) begin
                @(posedge clk);
                for (int i = 0; i < IN_LANES; i++)
                    in_entry[i] <= rnd(b, i);
                wr(1 + b % 6, 1);
            end
            drain;
            $display("random traffic mode %0d done", m);
        end
        // Stalled renamer: queue must close at its depth
        @(posedge clk);
        mode_64 <= 1'b0;
        hold <= 1'b1;
        slow <= 1'b0;
        for (int b = 0; b < 5; b++) begin
            @(posedge clk);
            for (int i = 0; i < IN_LANES; i++)
                in_entry[i] <= ent(512 + serial + i, 1, 0, 1'b0);
            serial += IN_LANES;
            wr(6, 0);
            n += 6 * got;
        end
        #1;
        chk(48'(n >= 13 && n <= QUEUE_DEPTH + 5), 48'h1);
        chk(48'(in_ready), 48'h0);
        @(posedge clk);
        hold <= 1'b0;
        drain;
        $display("fill test done");
        loop_try(QUEUE_DEPTH, 1'b0);
        loop_try(4, 1'b1);
        stop_test;
    end
endmodule // tb_instruction_queue_and_decode
`default_nettype wire
